// ==== usb_ps2_status_control_regs.sv ====
/*
 * USB / PS2 status and control register pair with its interrupt status,
 * mask and the shared minus/plus pin multiplexer.
 * Assumes an Avalon-MM master on i_sys_clk, a serial interface engine on
 * the same clock, and pins that arrive asynchronously.
 */
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Bit 0 of the control/status register reads 1 while the link is suspended.
// - Writing 1 to bit 1 sends a remote wake-up pulse; the bit reads 0.
// - Bit 2 is set on a detected bus reset, is read/write and resets to 0.
// - Bit 3 is set on a host resume and is read-only, reset 0.
// - Write-only bits 6 and 7 drive the data and clock pins in PS2 mode, reset 1.
// - A host endpoint access sets its flag and raises the interrupt if enabled and stack not full.
// - The control endpoint flag stays set until firmware clears it, holding the next event off.
// - The interrupt endpoint flag is set on an endpoint 1 event and cleared by firmware.
// - Bit 4 of the endpoint register selects PS2 operation, reset 0.
// - Bit 5 of the endpoint register selects USB operation, reset 0.
// - Bit 7 of the endpoint register is a read/write firmware marker, reset 0.
// - PS2 alone maps minus to data and plus to clock; USB alone lets the engine drive.
// - The data and clock input bits show the pin level gated by the output bit.
// - After more than 3 ms of bus idle in USB mode the device enters suspend and interrupts.
module usb_ps2_status_control_regs
   import usb_ps2_regs_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = IDLE_CYCLES_DEF
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire sie_events_s i_sie_events,
   input wire pin_drive_s i_sie_drive,
   input wire line_pins_s i_pins,
   output pin_drive_s o_pins,
   input wire logic i_usb_int_enable,
   input wire logic i_stack_full,
   output logic o_usb_irq,
   output logic o_remote_wake_pulse,
   output logic [1:0] o_ep_busy
);

   // -------------------------------------------------------------------
   // types, helpers and state
   // -------------------------------------------------------------------
   typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;
   typedef enum logic [1:0] {MODE_NONE, MODE_LEGACY, MODE_USB} link_mode_e;

   // byte address match for a register index
   function automatic logic addr_is(input logic [7:0] addr,
                                    input logic [7:0] idx);
      addr_is = addr == {idx[5:0], 2'b00};
   endfunction

   bus_state_e bus_state;
   link_mode_e link_mode;
   line_pins_s pin_meta, pin_sync, pin_prev;
   logic bus_req, wr_fire, wr_cs, wr_es, wr_st, wr_mask, line_activity;
   logic [7:0] wdata, control_status, ep_event_select;
   logic bus_reset_event, resume_indication, resume_rise;
   logic kbd_data_drive, kbd_clk_drive, kbd_data_in, kbd_clk_in;
   logic ctrl_ep_request, intr_ep_request, usb_mode_marker;
   logic legacy_port_select, serial_bus_select, suspend, suspend_change;
   logic [IRQ_W-1:0] irq_status, irq_mask, irq_events, next_irq_status;
   logic [31:0] next_readdata;

   // -------------------------------------------------------------------
   // avalon slave handshake
   // -------------------------------------------------------------------
   assign bus_req = i_avs_read || i_avs_write;

   // one wait cycle: read data is captured as waitrequest drops
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bus_state <= BUS_IDLE;
         o_avs_waitrequest <= 1'b1;
      end
      else
      begin
         o_avs_waitrequest <= !(bus_state == BUS_IDLE && bus_req);
         unique case (bus_state)
            BUS_IDLE:
               if (bus_req)
                  bus_state <= BUS_ACK;
            BUS_ACK:
               bus_state <= BUS_IDLE;
         endcase
      end
   end

   // writes take effect at the edge that sees waitrequest low
   assign wr_fire = bus_state == BUS_ACK && i_avs_write &&
                    i_avs_byteenable[0];
   assign wdata = i_avs_writedata[7:0];
   assign wr_cs = wr_fire && addr_is(i_avs_address, IDX_CONTROL_STATUS);
   assign wr_es = wr_fire && addr_is(i_avs_address, IDX_EP_EVENT_SELECT);
   assign wr_st = wr_fire && addr_is(i_avs_address, IDX_IRQ_STATUS);
   assign wr_mask = wr_fire && addr_is(i_avs_address, IDX_IRQ_MASK);

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   // pins are asynchronous; only pin_sync and pin_prev feed any logic
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_meta <= '1; // lines idle high: no false edge after reset
         pin_sync <= '1;
         pin_prev <= '1;
      end
      else
      begin
         pin_meta <= i_pins;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign line_activity = pin_sync != pin_prev;

   // open-drain style read-back: a low drive masks the pin
   assign kbd_data_in = pin_sync.minus_line & kbd_data_drive;
   assign kbd_clk_in = pin_sync.plus_line & kbd_clk_drive;

   // -------------------------------------------------------------------
   // mode selection and suspend detection
   // -------------------------------------------------------------------
   // both bits set is treated like none: no driver wins the pins
   always_comb
   begin
      if (legacy_port_select && !serial_bus_select)
         link_mode = MODE_LEGACY;
      else if (serial_bus_select && !legacy_port_select)
         link_mode = MODE_USB;
      else
         link_mode = MODE_NONE;
   end

   bus_idle_timer #(.IDLE_CYCLES(IDLE_CYCLES)) idle_timer (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_enable(link_mode == MODE_USB), .i_activity(line_activity),
      .i_resume_active(i_sie_events.resume_signal),
      .o_suspend(suspend), .o_change(suspend_change)
   );

   // -------------------------------------------------------------------
   // control/status register
   // -------------------------------------------------------------------
   // bus reset flag: hardware set beats a software clear
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         bus_reset_event <= 1'b0;
      else if (i_sie_events.bus_reset)
         bus_reset_event <= 1'b1;
      else if (wr_cs)
         bus_reset_event <= wdata[CS_BUS_RESET];
   end

   // resume bit mirrors the host signalling; firmware must latch it
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         resume_indication <= 1'b0;
      else
         resume_indication <= i_sie_events.resume_signal;
   end

   assign resume_rise = i_sie_events.resume_signal && !resume_indication;

   // write-only drive bits for the keyboard/mouse pins
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         kbd_data_drive <= KBD_DRIVE_RESET;
         kbd_clk_drive <= KBD_DRIVE_RESET;
      end
      else if (wr_cs)
      begin
         kbd_data_drive <= wdata[CS_KBD_DATA_DRIVE];
         kbd_clk_drive <= wdata[CS_KBD_CLK_DRIVE];
      end
   end

   // remote wake-up is a single-cycle pulse to the engine
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_remote_wake_pulse <= 1'b0;
      else
         o_remote_wake_pulse <= wr_cs && wdata[CS_REMOTE_WAKE];
   end

   // -------------------------------------------------------------------
   // endpoint event/select register
   // -------------------------------------------------------------------
   // endpoint flags: an access in the clearing cycle is kept
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_ep_request <= 1'b0;
         intr_ep_request <= 1'b0;
      end
      else
      begin
         if (i_sie_events.ep_access[0])
            ctrl_ep_request <= 1'b1;
         else if (wr_es)
            ctrl_ep_request <= wdata[ES_CTRL_EP];
         if (i_sie_events.ep_access[1])
            intr_ep_request <= 1'b1;
         else if (wr_es)
            intr_ep_request <= wdata[ES_INTR_EP];
      end
   end

   // engine must hold the next endpoint event while its flag is set
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_ep_busy <= 2'h0;
      else
         o_ep_busy <= {intr_ep_request, ctrl_ep_request};
   end

   // select bits and firmware marker; reserved bits are not stored
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         legacy_port_select <= 1'b0;
         serial_bus_select <= 1'b0;
         usb_mode_marker <= 1'b0;
      end
      else if (wr_es)
      begin
         legacy_port_select <= wdata[ES_LEGACY_SEL];
         serial_bus_select <= wdata[ES_SERIAL_SEL];
         usb_mode_marker <= wdata[ES_MODE_MARKER];
      end
   end

   // -------------------------------------------------------------------
   // interrupt status and mask
   // -------------------------------------------------------------------
   assign irq_events = {suspend_change, resume_rise, i_sie_events.bus_reset,
                        i_sie_events.ep_access};

   // write-one-to-clear, with a new event winning over the clear
   always_comb
   begin
      next_irq_status = irq_status;
      if (wr_st)
         next_irq_status = irq_status & ~wdata[IRQ_W-1:0];
      next_irq_status = next_irq_status | irq_events;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         irq_status <= '0;
      else
         irq_status <= next_irq_status;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         irq_mask <= IRQ_MASK_RESET;
      else if (wr_mask)
         irq_mask <= wdata[IRQ_W-1:0];
   end

   // level request; pending endpoint flags keep it up until cleared
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_usb_irq <= 1'b0;
      else
         o_usb_irq <= i_usb_int_enable && !i_stack_full &&
                      ((|(irq_status & irq_mask)) ||
                       ctrl_ep_request || intr_ep_request);
   end

   // -------------------------------------------------------------------
   // shared pin drivers
   // -------------------------------------------------------------------
   // ps2 lines are open drain: a zero bit pulls the line low
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_pins <= '0;
      else
         unique case (link_mode)
            MODE_LEGACY:
               o_pins <= {1'b0, !kbd_data_drive, 1'b0, !kbd_clk_drive};
            MODE_USB:
               o_pins <= i_sie_drive;
            default:
               o_pins <= '0;
         endcase
   end

   // -------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------
   // write-only and reserved bits read as zero
   always_comb
   begin
      control_status = 8'h00;
      control_status[CS_SUSPEND] = suspend;
      control_status[CS_BUS_RESET] = bus_reset_event;
      control_status[CS_RESUME] = resume_indication;
      control_status[CS_KBD_DATA_IN] = kbd_data_in;
      control_status[CS_KBD_CLK_IN] = kbd_clk_in;
      ep_event_select = 8'h00;
      ep_event_select[ES_CTRL_EP] = ctrl_ep_request;
      ep_event_select[ES_INTR_EP] = intr_ep_request;
      ep_event_select[ES_LEGACY_SEL] = legacy_port_select;
      ep_event_select[ES_SERIAL_SEL] = serial_bus_select;
      ep_event_select[ES_MODE_MARKER] = usb_mode_marker;
   end

   // unmapped addresses answer with zero
   always_comb
   begin
      next_readdata = 32'h0000_0000;
      if (addr_is(i_avs_address, IDX_CONTROL_STATUS))
         next_readdata[7:0] = control_status;
      else if (addr_is(i_avs_address, IDX_EP_EVENT_SELECT))
         next_readdata[7:0] = ep_event_select;
      else if (addr_is(i_avs_address, IDX_IRQ_STATUS))
         next_readdata[IRQ_W-1:0] = irq_status;
      else if (addr_is(i_avs_address, IDX_IRQ_MASK))
         next_readdata[IRQ_W-1:0] = irq_mask;
   end

   // captured on the edge that drops waitrequest, held through the ack
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         o_avs_readdata <= 32'h0000_0000;
      else if (bus_state == BUS_IDLE && i_avs_read)
         o_avs_readdata <= next_readdata;
   end

endmodule

`default_nettype wire

// ==== usb_ps2_regs_pkg.sv ====
/*
 * Shared constants and carriers for the USB / PS2 status and control
 * register pair: register indices, bit positions, reset values, the
 * bus-idle timing and the packed structs used on the pin and engine sides.
 * Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`default_nettype none

package usb_ps2_regs_pkg;

   // ------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_CONTROL_STATUS = 8'h1a;
   localparam logic [7:0] IDX_EP_EVENT_SELECT = 8'h1b;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h21;

   // ------------------------------------------------------------------
   // control/status bit positions
   // ------------------------------------------------------------------
   localparam int CS_SUSPEND = 0;
   localparam int CS_REMOTE_WAKE = 1;
   localparam int CS_BUS_RESET = 2;
   localparam int CS_RESUME = 3;
   localparam int CS_KBD_DATA_IN = 4;
   localparam int CS_KBD_CLK_IN = 5;
   localparam int CS_KBD_DATA_DRIVE = 6;
   localparam int CS_KBD_CLK_DRIVE = 7;

   // ------------------------------------------------------------------
   // endpoint event/select bit positions
   // ------------------------------------------------------------------
   localparam int ES_CTRL_EP = 0;
   localparam int ES_INTR_EP = 1;
   localparam int ES_LEGACY_SEL = 4;
   localparam int ES_SERIAL_SEL = 5;
   localparam int ES_MODE_MARKER = 7;

   // ------------------------------------------------------------------
   // interrupt status/mask layout and reset values
   // ------------------------------------------------------------------
   localparam int IRQ_W = 5;
   localparam int IRQ_CTRL_EP = 0;
   localparam int IRQ_INTR_EP = 1;
   localparam int IRQ_BUS_RESET = 2;
   localparam int IRQ_RESUME = 3;
   localparam int IRQ_SUSPEND = 4;
   localparam logic [4:0] IRQ_MASK_RESET = 5'h1f;
   localparam logic KBD_DRIVE_RESET = 1'b1;

   // ------------------------------------------------------------------
   // bus idle timing before suspend
   // ------------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 200;
   localparam int SUSPEND_IDLE_MS = 3;
   localparam int IDLE_CYCLES_DEF = SUSPEND_IDLE_MS * SYS_CLK_MHZ * 1000;
   localparam int IDLE_CNT_W = 24;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic minus_line;
      logic plus_line;
   } line_pins_s;

   typedef struct packed {
      logic minus_out;
      logic minus_oe;
      logic plus_out;
      logic plus_oe;
   } pin_drive_s;

   typedef struct packed {
      logic [1:0] ep_access;
      logic bus_reset;
      logic resume_signal;
   } sie_events_s;

endpackage

`default_nettype wire

// ==== bus_idle_timer.sv ====
/*
 * Bus idle timer: counts system clocks without line activity and holds
 * the suspend level once the idle time has passed.
 * Assumes activity and resume come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module bus_idle_timer
   import usb_ps2_regs_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = IDLE_CYCLES_DEF
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic i_activity,
   input wire logic i_resume_active,
   output logic o_suspend,
   output logic o_change
);

   localparam logic [IDLE_CNT_W-1:0] LIMIT = IDLE_CNT_W'(IDLE_CYCLES);

   logic [IDLE_CNT_W-1:0] idle_count;
   logic next_suspend;

   // idle counter restarts on every line change
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         idle_count <= '0;
      else if (!i_enable || i_activity)
         idle_count <= '0;
      else if (idle_count != LIMIT)
         idle_count <= idle_count + 1'b1;
   end

   // suspend stays up through resume signalling, drops after it
   always_comb
   begin
      next_suspend = o_suspend;
      if (!i_enable)
         next_suspend = 1'b0;
      else if (idle_count == LIMIT && !i_activity)
         next_suspend = 1'b1;
      else if (i_activity && !i_resume_active)
         next_suspend = 1'b0;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_suspend <= 1'b0;
         o_change <= 1'b0;
      end
      else
      begin
         o_suspend <= next_suspend;
         o_change <= next_suspend != o_suspend;
      end
   end

endmodule

`default_nettype wire

// ==== usb_ps2_regs_checker.sv ====
/*
 checker for the register pair: bus handshake, event flags, irq, pins.
 assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_ps2_regs_checker
   import usb_ps2_regs_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire sie_events_s i_sie_events,
   input wire pin_drive_s i_sie_drive,
   input wire pin_drive_s o_pins,
   input wire logic i_usb_int_enable,
   input wire logic i_stack_full,
   input wire logic o_usb_irq,
   input wire logic o_remote_wake_pulse,
   input wire logic [1:0] o_ep_busy
);
   // ----------------------------------------------------------------
   // one clock domain, so clocking and reset are given once
   // ----------------------------------------------------------------
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence req_s;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence answer_s;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   // bus answers after exactly one wait cycle, low for one cycle
   wait_one_a: assert property (req_s |=> answer_s)
      else $error("bus answer timing off");
   rdata_hi_a: assert property (!o_avs_waitrequest && i_avs_read
      |-> o_avs_readdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   // flags show two edges after the engine pulse
   ep0_busy_a: assert property (
      i_sie_events.ep_access[0] |-> ##2 o_ep_busy[0])
      else $error("control endpoint flag missing");
   ep1_busy_a: assert property (
      i_sie_events.ep_access[1] |-> ##2 o_ep_busy[1])
      else $error("interrupt endpoint flag missing");
   irq_gate_a: assert property (
      o_usb_irq |-> $past(i_usb_int_enable) && !$past(i_stack_full))
      else $error("irq while disabled or stack full");
   busy_irq_a: assert property (
      o_ep_busy != 2'b00 && $past(i_usb_int_enable)
      && !$past(i_stack_full) |-> o_usb_irq)
      else $error("pending flag without irq");
   wake_one_a: assert property (
      o_remote_wake_pulse |=> !o_remote_wake_pulse)
      else $error("wake pulse longer than one cycle");
   // a high pin level can only come from the engine in usb mode
   minus_src_a: assert property (
      o_pins.minus_out |-> $past(i_sie_drive.minus_out))
      else $error("minus level without engine source");
   plus_src_a: assert property (
      o_pins.plus_out |-> $past(i_sie_drive.plus_out))
      else $error("plus level without engine source");
endmodule
bind usb_ps2_status_control_regs usb_ps2_regs_checker
   chk_i (.i_sys_clk(i_sys_clk),
   .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest),
   .i_sie_events(i_sie_events), .i_sie_drive(i_sie_drive),
   .o_pins(o_pins), .i_usb_int_enable(i_usb_int_enable),
   .i_stack_full(i_stack_full), .o_usb_irq(o_usb_irq),
   .o_remote_wake_pulse(o_remote_wake_pulse), .o_ep_busy(o_ep_busy));
`default_nettype wire

// ==== usb_host_model.sv ====
/*
 host side of the shared lines: engine event source and wired lines.
 assumes the bench requests events and pull-downs by level.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_host_model
   import usb_ps2_regs_pkg::*;
(
   input wire pin_drive_s i_dev,
   input wire logic [1:0] i_busy,
   input wire logic [1:0] i_ep_req,
   input wire logic i_reset_req,
   input wire logic i_resume_req,
   input wire logic [1:0] i_host_low,
   output sie_events_s o_events,
   output line_pins_s o_lines
);
   // ----------------------------------------------------------------
   // events: no new endpoint event while firmware owns the flag
   // ----------------------------------------------------------------
   always_comb
   begin
      o_events.ep_access = i_ep_req & ~i_busy;
      o_events.bus_reset = i_reset_req;
      o_events.resume_signal = i_resume_req;
   end
   // pulled-up lines: low if anybody drives low, high otherwise
   always_comb
   begin
      o_lines.minus_line = !((i_dev.minus_oe && !i_dev.minus_out)
         || i_host_low[1]);
      o_lines.plus_line = !((i_dev.plus_oe && !i_dev.plus_out)
         || i_host_low[0]);
   end
endmodule
`default_nettype wire

// ==== usb_ps2_status_control_regs_tb_top.sv ====
/*
 self-checking bench for the register pair over avalon-mm.
 assumes the checker is bound and the host model closes the pins.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_ps2_status_control_regs_tb_top;
   import usb_ps2_regs_pkg::*;
   localparam int IDLE = 40;
   logic sys_clk, rst, rd, wr, int_en, stk_full, irq, wake, wait_rq;
   logic rst_req, res_req;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [1:0] busy, ep_req, host_low;
   pin_drive_s sie_drive, drv;
   line_pins_s pins;
   sie_events_s ev;
   int n_errors = 0, checked = 0, cyc = 0, wakes = 0;
   usb_ps2_status_control_regs #(.IDLE_CYCLES(IDLE))
      usb_ps2_status_control_regs_i (.i_sys_clk(sys_clk), .i_rst(rst),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
      .i_sie_events(ev), .i_sie_drive(sie_drive), .i_pins(pins),
      .o_pins(drv), .i_usb_int_enable(int_en), .i_stack_full(stk_full),
      .o_usb_irq(irq), .o_remote_wake_pulse(wake), .o_ep_busy(busy));
   usb_host_model usb_host_model_i (.i_dev(drv), .i_busy(busy),
      .i_ep_req(ep_req), .i_reset_req(rst_req), .i_resume_req(res_req),
      .i_host_low(host_low), .o_events(ev), .o_lines(pins));
   // ----------------------------------------------------------------
   // clock, wake counter and hang guard
   // ----------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
      if (cyc == 3000)
      begin
         n_errors++;
         report_and_stop;
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task report_and_stop;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // one request, held until waitrequest is seen low at an edge
   task bus(input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      rd <= r;
      wr <= !r;
      addr <= a;
      wdata <= {24'h0, d};
      @(posedge sys_clk);
      while (wait_rq !== 1'b0) @(posedge sys_clk);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task rc(input logic [7:0] a, input logic [7:0] e, input string n);
      bus(1'b1, a, 8'h00);
      chk(n, {24'h0, e}, q);
   endtask
   task wt(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task pulse(input logic [2:0] b);
      @(posedge sys_clk);
      {ep_req, rst_req} <= b;
      @(posedge sys_clk);
      {ep_req, rst_req} <= 3'h0;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst, rd, wr, int_en, stk_full, rst_req, res_req} = 7'h40;
      {addr, wdata, ep_req, host_low} = '0;
      sie_drive = '0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rc(8'h68, 8'h30, "cs reset");
      rc(8'h6c, 8'h00, "es reset");
      rc(8'h80, 8'h00, "irq status reset");
      rc(8'h84, 8'h1f, "irq mask reset");
      rc(8'h70, 8'h00, "unmapped read");
      chk("pins reset", 32'h0, drv);
      bus(1'b0, 8'h6c, 8'hb0);
      rc(8'h6c, 8'hb0, "es fields");
      // ps2 mode: data released, clock driven low
      bus(1'b0, 8'h6c, 8'h10);
      bus(1'b0, 8'h68, 8'h40);
      wt(3);
      chk("ps2 pins", 32'h1, drv);
      rc(8'h68, 8'h10, "ps2 inputs");
      @(posedge sys_clk) host_low <= 2'b10;
      wt(4);
      rc(8'h68, 8'h00, "ps2 data low");
      @(posedge sys_clk) host_low <= 2'b00;
      // usb mode hands pins to the engine; both selected hands to none
      @(posedge sys_clk) sie_drive <= 4'b1011;
      bus(1'b0, 8'h6c, 8'h20);
      wt(3);
      chk("usb pins", 32'hb, drv);
      bus(1'b0, 8'h6c, 8'h30);
      wt(3);
      chk("both pins", 32'h0, drv);
      @(posedge sys_clk) sie_drive <= '0;
      bus(1'b0, 8'h6c, 8'h00);
      bus(1'b0, 8'h80, 8'h1f);
      // endpoint events, clears, stack full
      @(posedge sys_clk) int_en <= 1'b1;
      pulse(3'b010);
      wt(3);
      chk("busy ep0", 32'h1, busy);
      chk("irq ep0", 32'h1, irq);
      pulse(3'b010);
      rc(8'h6c, 8'h01, "es ep0");
      bus(1'b0, 8'h6c, 8'h00);
      wt(3);
      chk("busy cleared", 32'h0, busy);
      chk("irq pending", 32'h1, irq);
      bus(1'b0, 8'h80, 8'h1f);
      wt(3);
      chk("irq cleared", 32'h0, irq);
      @(posedge sys_clk) stk_full <= 1'b1;
      pulse(3'b100);
      wt(3);
      chk("irq stack full", 32'h0, irq);
      rc(8'h6c, 8'h02, "es ep1");
      @(posedge sys_clk) stk_full <= 1'b0;
      wt(3);
      chk("irq ep1", 32'h1, irq);
      bus(1'b0, 8'h6c, 8'h00);
      bus(1'b0, 8'h80, 8'h1f);
      // masked bus reset, then unmasked
      bus(1'b0, 8'h84, 8'h00);
      pulse(3'b001);
      wt(3);
      chk("irq masked", 32'h0, irq);
      rc(8'h68, 8'h14, "bus reset flag");
      bus(1'b0, 8'h84, 8'h1f);
      wt(3);
      chk("irq unmasked", 32'h1, irq);
      bus(1'b0, 8'h68, 8'hc0);
      rc(8'h68, 8'h30, "bus reset cleared");
      bus(1'b0, 8'h80, 8'h1f);
      // remote wake and resume
      bus(1'b0, 8'h68, 8'hc2);
      wt(3);
      chk("wake pulses", 32'h1, wakes);
      @(posedge sys_clk) res_req <= 1'b1;
      wt(4);
      rc(8'h68, 8'h38, "resume bit");
      @(posedge sys_clk) res_req <= 1'b0;
      wt(4);
      rc(8'h80, 8'h08, "resume status");
      bus(1'b0, 8'h80, 8'h1f);
      // quiet usb lines lead to suspend; a line change leaves it
      bus(1'b0, 8'h6c, 8'h20);
      wt(IDLE + 10);
      rc(8'h68, 8'h31, "suspend bit");
      rc(8'h80, 8'h10, "suspend status");
      @(posedge sys_clk) host_low <= 2'b01;
      wt(6);
      rc(8'h68, 8'h10, "suspend left");
      report_and_stop;
   end
endmodule
`default_nettype wire
